// >>> hdl/pcs_regs.svh
// register offsets, field positions, constants and reset values for the config register bank
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
`define PCS_OFF_WIN_BASE 12'h010
`define PCS_OFF_IRQ_FN0 12'h03c
`define PCS_OFF_IDENT_FN1 12'h100
`define PCS_OFF_CMDSTAT_FN1 12'h104
`define PCS_WIN_LSB 12
`define PCS_IRQ_PIN_VAL 8'h01
`define PCS_MIN_GRANT_VAL 8'h05
`define PCS_MAX_LAT_VAL 8'h0f
`define PCS_CMD_MEM_BIT 1
`define PCS_CMD_PAR_BIT 6
`define PCS_CMD_SERR_BIT 8
`define PCS_ST_FBB_BIT 23
`define PCS_ST_TIM0_BIT 25
`define PCS_ST_TIM1_BIT 26
`define PCS_ST_TARGET_ABORT_SIGNALLED_BIT 27
`define PCS_ST_SERR_BIT 30
`define PCS_ST_PERR_BIT 31
`define PCS_ST_STICKY_MASK 32'hc8000000
`define PCS_RST_WIN_BASE 20'h00000
`define PCS_RST_IRQ_LINE 8'h00
`define PCS_RST_CMD 3'h0
`endif

// >>> hdl/pcs_pkg.sv
// types shared by the config register bank
package pcs_pkg;
    // one configuration access as presented by the host side
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcs_cfg_req_type;
    // one memory access aimed at the device
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } pcs_mem_req_type;
    // register selected by a configuration address
    typedef enum logic [2:0] {
        PCS_SEL_NONE,
        PCS_SEL_WIN,
        PCS_SEL_IRQ,
        PCS_SEL_IDENT,
        PCS_SEL_CMDST
    } pcs_sel_type;
endpackage

// >>> hdl/pcs_status_bits.sv
// sticky status bits of the bridge function, set by events and cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module pcs_status_bits #(
    parameter int WIDTH = 3
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [WIDTH-1:0] SET,
    input wire logic [WIDTH-1:0] CLR,
    output logic [WIDTH-1:0] Q
);
    logic [WIDTH-1:0] bits_ff;
    logic [WIDTH-1:0] nxt_bits;
    genvar i;
    // each bit: a set in the same cycle as a clear wins
    assign nxt_bits = SET | (bits_ff & ~CLR);
    // all status bits register together
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bits_ff <= {WIDTH{1'b0}};
        end else begin
            bits_ff <= nxt_bits;
        end
    end
    // per-bit checks of set priority and clearing
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            property p_set_wins;
                @(posedge CLK) disable iff (!RST_N) SET[i] |=> bits_ff[i];
            endproperty
            a_set_wins: assert property (p_set_wins) else $error("status bit lost its set");
            property p_clear_works;
                @(posedge CLK) disable iff (!RST_N) (CLR[i] && !SET[i]) |=> !bits_ff[i];
            endproperty
            a_clear_works: assert property (p_clear_works) else $error("status bit not cleared");
        end
    endgenerate
    assign Q = bits_ff;
endmodule
`default_nettype wire

// >>> hdl/pcs_config_regs.sv
// configuration register bank: register window base, fn0 irq register, bridge ident and cmd/status
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module pcs_config_regs #(
    parameter logic [15:0] MAKER_CODE = 16'h5a5a, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'ha5a5 // arbitrary value
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire pcs_pkg::pcs_cfg_req_type CFG_REQ,
    output logic [31:0] CFG_RDATA,
    output logic CFG_ACK,
    input wire pcs_pkg::pcs_mem_req_type MEM_REQ,
    input wire logic MEM_IS_LOCAL,
    input wire logic IO_REQ,
    output logic WIN_HIT,
    output logic LOCAL_HIT,
    output logic IO_HIT,
    input wire logic TARGET_ABORT_EVT,
    input wire logic PARITY_ERR_EVT,
    input wire logic SERR_EVT,
    output logic SYSTEM_ERROR_OUT_N,
    output logic PARITY_ACT
);
    // decode of a configuration address to a register
    function automatic pcs_pkg::pcs_sel_type dec_sel(input logic [11:0] a);
        case (a)
            `PCS_OFF_WIN_BASE: dec_sel = pcs_pkg::PCS_SEL_WIN;
            `PCS_OFF_IRQ_FN0: dec_sel = pcs_pkg::PCS_SEL_IRQ;
            `PCS_OFF_IDENT_FN1: dec_sel = pcs_pkg::PCS_SEL_IDENT;
            `PCS_OFF_CMDSTAT_FN1: dec_sel = pcs_pkg::PCS_SEL_CMDST;
            default: dec_sel = pcs_pkg::PCS_SEL_NONE;
        endcase
    endfunction

    // byte lane merge for writable fields
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    logic [19:0] win_base_ff;
    logic [7:0] irq_line_ff;
    logic mem_en_ff;
    logic par_en_ff;
    logic serr_en_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic serr_out_ff;
    logic [19:0] nxt_win_base;
    logic [7:0] nxt_irq_line;
    logic nxt_mem_en;
    logic nxt_par_en;
    logic nxt_serr_en;
    logic [31:0] nxt_rdata;
    logic [2:0] st_q;
    logic [2:0] st_clr;
    logic [2:0] st_set;

    // access decode
    pcs_pkg::pcs_sel_type sel;
    wire [31:0] wmask = be_mask(CFG_REQ.be);
    wire wr_go = CFG_REQ.valid & CFG_REQ.write;
    wire wr_win = wr_go & (sel == pcs_pkg::PCS_SEL_WIN);
    wire wr_irq = wr_go & (sel == pcs_pkg::PCS_SEL_IRQ);
    wire wr_cmd = wr_go & (sel == pcs_pkg::PCS_SEL_CMDST);
    wire [31:0] wmerged = CFG_REQ.wdata & wmask;
    assign sel = dec_sel(CFG_REQ.addr);

    // read views of each register
    wire [31:0] win_view = {win_base_ff, 12'h000};
    wire [31:0] irq_view = {`PCS_MAX_LAT_VAL, `PCS_MIN_GRANT_VAL,
        `PCS_IRQ_PIN_VAL, irq_line_ff};
    wire [31:0] ident_view = {PART_CODE, MAKER_CODE};
    wire [15:0] cmd_view = {7'h00, serr_en_ff, 1'b0, par_en_ff, 4'h0,
        mem_en_ff, 1'b0};
    wire [15:0] stat_view = {st_q[2], st_q[1], 2'b00, st_q[0], 2'b01, 1'b0, 1'b1,
        7'h00};
    wire [31:0] cmdst_view = {stat_view, cmd_view};

    // read data select
    assign nxt_rdata = (sel == pcs_pkg::PCS_SEL_WIN) ? win_view :
        (sel == pcs_pkg::PCS_SEL_IRQ) ? irq_view :
        (sel == pcs_pkg::PCS_SEL_IDENT) ? ident_view :
        (sel == pcs_pkg::PCS_SEL_CMDST) ? cmdst_view : 32'h00000000;

    // writable field next values; read-only bits have no storage
    assign nxt_win_base = wr_win ? ((wmerged[31:12]) | (win_base_ff & ~wmask[31:12]))
        : win_base_ff;
    assign nxt_irq_line = wr_irq ? ((wmerged[7:0]) | (irq_line_ff & ~wmask[7:0]))
        : irq_line_ff;
    assign nxt_mem_en = (wr_cmd & CFG_REQ.be[0]) ? CFG_REQ.wdata[`PCS_CMD_MEM_BIT]
        : mem_en_ff;
    assign nxt_par_en = (wr_cmd & CFG_REQ.be[0]) ? CFG_REQ.wdata[`PCS_CMD_PAR_BIT]
        : par_en_ff;
    assign nxt_serr_en = (wr_cmd & CFG_REQ.be[1]) ? CFG_REQ.wdata[`PCS_CMD_SERR_BIT]
        : serr_en_ff;

    // write-one-to-clear on status lanes 3, events set
    assign st_clr = wr_cmd ? {wmerged[`PCS_ST_PERR_BIT], wmerged[`PCS_ST_SERR_BIT],
        wmerged[`PCS_ST_TARGET_ABORT_SIGNALLED_BIT]} : 3'h0;
    assign st_set = {PARITY_ERR_EVT, SERR_EVT, TARGET_ABORT_EVT};

    pcs_status_bits #(
        .WIDTH(3)
    ) u_status (
        .CLK(CLK),
        .RST_N(RST_N),
        .SET(st_set),
        .CLR(st_clr),
        .Q(st_q)
    );

    // register state
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            win_base_ff <= `PCS_RST_WIN_BASE;
            irq_line_ff <= `PCS_RST_IRQ_LINE;
            {mem_en_ff, par_en_ff, serr_en_ff} <= `PCS_RST_CMD;
        end else begin
            win_base_ff <= nxt_win_base;
            irq_line_ff <= nxt_irq_line;
            mem_en_ff <= nxt_mem_en;
            par_en_ff <= nxt_par_en;
            serr_en_ff <= nxt_serr_en;
        end
    end

    // one-cycle answer to every configuration access
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_ff <= 32'h00000000;
            ack_ff <= 1'b0;
            serr_out_ff <= 1'b1;
        end else begin
            rdata_ff <= (CFG_REQ.valid & ~CFG_REQ.write) ? nxt_rdata : rdata_ff;
            ack_ff <= CFG_REQ.valid;
            serr_out_ff <= ~(SERR_EVT & serr_en_ff);
        end
    end

    // memory and io decode; configuration accesses stay open at all times
    wire cmd_all_zero = (cmd_view == 16'h0000);
    assign WIN_HIT = MEM_REQ.valid & ~MEM_IS_LOCAL &
        (MEM_REQ.addr[31:`PCS_WIN_LSB] == win_base_ff);
    assign LOCAL_HIT = MEM_REQ.valid & MEM_IS_LOCAL & mem_en_ff & ~cmd_all_zero;
    assign IO_HIT = IO_REQ & 1'b0;
    assign CFG_RDATA = rdata_ff;
    assign CFG_ACK = ack_ff;
    assign SYSTEM_ERROR_OUT_N = serr_out_ff;
    assign PARITY_ACT = par_en_ff & PARITY_ERR_EVT;

    // checks
    property p_ack_one;
        @(posedge CLK) disable iff (!RST_N) CFG_REQ.valid |=> CFG_ACK;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("config access not acked");
    property p_win_low;
        @(posedge CLK) disable iff (!RST_N)
        (CFG_REQ.valid && !CFG_REQ.write && sel == pcs_pkg::PCS_SEL_WIN)
        |=> CFG_RDATA[11:0] == 12'h000;
    endproperty
    a_win_low: assert property (p_win_low) else $error("window low bits nonzero");
    property p_win_store;
        @(posedge CLK) disable iff (!RST_N)
        (wr_win && CFG_REQ.be == 4'hf) |=> win_base_ff == $past(CFG_REQ.wdata[31:12]);
    endproperty
    a_win_store: assert property (p_win_store) else $error("window base not stored");
    property p_irq_const;
        @(posedge CLK) disable iff (!RST_N)
        (CFG_REQ.valid && !CFG_REQ.write && sel == pcs_pkg::PCS_SEL_IRQ)
        |=> CFG_RDATA[31:8] == 24'h0f0501;
    endproperty
    a_irq_const: assert property (p_irq_const) else $error("irq constants wrong");
    property p_ident;
        @(posedge CLK) disable iff (!RST_N)
        (CFG_REQ.valid && !CFG_REQ.write && sel == pcs_pkg::PCS_SEL_IDENT)
        |=> CFG_RDATA == {PART_CODE, MAKER_CODE};
    endproperty
    a_ident: assert property (p_ident) else $error("ident code wrong");
    property p_cmd_ro;
        @(posedge CLK) disable iff (!RST_N)
        (CFG_REQ.valid && !CFG_REQ.write && sel == pcs_pkg::PCS_SEL_CMDST)
        |=> (CFG_RDATA[15:0] & 16'hfebd) == 16'h0000 && CFG_RDATA[26:16] == 11'h280;
    endproperty
    a_cmd_ro: assert property (p_cmd_ro) else $error("read-only command bits wrong");
    property p_local_gate;
        @(posedge CLK) disable iff (!RST_N) !mem_en_ff |-> !LOCAL_HIT;
    endproperty
    a_local_gate: assert property (p_local_gate) else $error("local hit while disabled");
    property p_serr_gate;
        @(posedge CLK) disable iff (!RST_N)
        !serr_en_ff ##1 !serr_en_ff |-> SYSTEM_ERROR_OUT_N;
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("system error while disabled");
    property p_serr_flag;
        @(posedge CLK) disable iff (!RST_N) SERR_EVT |=> st_q[1];
    endproperty
    a_serr_flag: assert property (p_serr_flag) else $error("system error flag not set");
    property p_io_never;
        @(posedge CLK) disable iff (!RST_N) !IO_HIT;
    endproperty
    a_io_never: assert property (p_io_never) else $error("io response");
    // answer, storage, status and decode checks
    property p_ack_only;
        @(posedge CLK) disable iff (!RST_N)
        CFG_ACK |-> $past(CFG_REQ.valid);
    endproperty
    a_ack_only: assert property (p_ack_only) else $error("ack without access");
    property p_rdata_hold;
        @(posedge CLK) disable iff (!RST_N)
        !(CFG_REQ.valid && !CFG_REQ.write) |=> $stable(CFG_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_irq_line_store;
        @(posedge CLK) disable iff (!RST_N)
        (wr_irq && CFG_REQ.be[0]) |=> irq_line_ff == $past(CFG_REQ.wdata[7:0]);
    endproperty
    a_irq_line_store: assert property (p_irq_line_store) else $error("irq line not stored");
    property p_mem_en_store;
        @(posedge CLK) disable iff (!RST_N)
        (wr_cmd && CFG_REQ.be[0]) |=> mem_en_ff == $past(CFG_REQ.wdata[`PCS_CMD_MEM_BIT]);
    endproperty
    a_mem_en_store: assert property (p_mem_en_store) else $error("memory enable not stored");
    property p_st_clear;
        @(posedge CLK) disable iff (!RST_N)
        (wr_cmd && wmerged[`PCS_ST_PERR_BIT] && !PARITY_ERR_EVT) |=> !st_q[2];
    endproperty
    a_st_clear: assert property (p_st_clear) else $error("parity flag not cleared");
    property p_st_no_set;
        @(posedge CLK) disable iff (!RST_N)
        (wr_cmd && !st_q[2] && !PARITY_ERR_EVT) |=> !st_q[2];
    endproperty
    a_st_no_set: assert property (p_st_no_set) else $error("write set a status bit");
    property p_target_abort_signalled_flag;
        @(posedge CLK) disable iff (!RST_N)
        TARGET_ABORT_EVT |=> st_q[0];
    endproperty
    a_target_abort_signalled_flag: assert property (p_target_abort_signalled_flag) else $error("target abort flag not set");
    property p_perr_flag;
        @(posedge CLK) disable iff (!RST_N)
        PARITY_ERR_EVT |=> st_q[2];
    endproperty
    a_perr_flag: assert property (p_perr_flag) else $error("parity flag not set");
    property p_serr_out;
        @(posedge CLK) disable iff (!RST_N)
        (SERR_EVT && serr_en_ff) |=> !SYSTEM_ERROR_OUT_N;
    endproperty
    a_serr_out: assert property (p_serr_out) else $error("system error not driven");
    property p_par_ignore;
        @(posedge CLK) disable iff (!RST_N)
        !par_en_ff |-> !PARITY_ACT;
    endproperty
    a_par_ignore: assert property (p_par_ignore) else $error("parity acted while off");
    property p_par_act;
        @(posedge CLK) disable iff (!RST_N)
        (PARITY_ERR_EVT && par_en_ff) |-> PARITY_ACT;
    endproperty
    a_par_act: assert property (p_par_act) else $error("parity error not acted on");
    property p_cmd_reset;
        @(posedge CLK) disable iff (!RST_N)
        $rose(RST_N) |-> !mem_en_ff && !par_en_ff && !serr_en_ff;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset) else $error("command bits not reset");
    property p_win_hit_match;
        @(posedge CLK) disable iff (!RST_N)
        (MEM_REQ.valid && !MEM_IS_LOCAL && MEM_REQ.addr[31:`PCS_WIN_LSB] == win_base_ff)
        |-> WIN_HIT;
    endproperty
    a_win_hit_match: assert property (p_win_hit_match) else $error("window hit missed");
    property p_local_open;
        @(posedge CLK) disable iff (!RST_N)
        (MEM_REQ.valid && MEM_IS_LOCAL && mem_en_ff) |-> LOCAL_HIT;
    endproperty
    a_local_open: assert property (p_local_open) else $error("local hit missed");
    c_win_hit: cover property (@(posedge CLK) disable iff (!RST_N) WIN_HIT);
    c_local_hit: cover property (@(posedge CLK) disable iff (!RST_N) LOCAL_HIT);
    c_clear: cover property (@(posedge CLK) disable iff (!RST_N) st_q[0] ##1 !st_q[0]);
    c_serr: cover property (@(posedge CLK) disable iff (!RST_N) !SYSTEM_ERROR_OUT_N);
    c_par_act: cover property (@(posedge CLK) disable iff (!RST_N) PARITY_ACT);
endmodule
`default_nettype wire

// >>> tb/pcs_host_model.sv
// host model issuing configuration accesses and memory probes
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
    input wire logic CLK,
    output pcs_pkg::pcs_cfg_req_type CFG_REQ,
    input wire logic CFG_ACK,
    input wire logic [31:0] CFG_RDATA,
    output pcs_pkg::pcs_mem_req_type MEM_REQ,
    output logic MEM_IS_LOCAL,
    output logic IO_REQ,
    input wire logic [2:0] HITS
);
    // idle bus at time zero
    initial begin
        CFG_REQ = '0;
        MEM_REQ = '0;
        MEM_IS_LOCAL = 1'b0;
        IO_REQ = 1'b0;
    end
    // one access: valid for a single edge, answer taken in the next cycle
    // local bus never enters configuration mode here, so bit 1 may be set
    task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q, output logic ack);
        @(posedge CLK);
        #1;
        CFG_REQ = {1'b1, wr, a, be, d};
        @(posedge CLK);
        #1;
        CFG_REQ = {1'b0, ~wr, ~a, ~be, ~d}; // released lines carry no stale value
        ack = CFG_ACK;
        q = CFG_RDATA;
    endtask
    // one memory or io probe, hit flags sampled once settled
    task automatic probe(input logic [31:0] a, input logic loc, input logic io,
                         output logic [2:0] hits);
        @(posedge CLK);
        #1;
        MEM_REQ = {1'b1, a};
        MEM_IS_LOCAL = loc;
        IO_REQ = io;
        #1;
        hits = HITS;
        @(posedge CLK);
        #1;
        MEM_REQ = {1'b0, ~a};
        IO_REQ = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/pcs_config_regs_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module pcs_config_regs_tb;
    localparam logic [31:0] IDENT = 32'ha5a5_5a5a; // arbitrary codes
    localparam logic [31:0] ST = 32'h0280_0000;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic TARGET_ABORT_EVT = 1'b0;
    logic PARITY_ERR_EVT = 1'b0;
    logic SERR_EVT = 1'b0;
    pcs_pkg::pcs_cfg_req_type CFG_REQ;
    pcs_pkg::pcs_mem_req_type MEM_REQ;
    logic [31:0] CFG_RDATA;
    logic CFG_ACK, MEM_IS_LOCAL, IO_REQ, WIN_HIT, LOCAL_HIT, IO_HIT;
    logic SYSTEM_ERROR_OUT_N, PARITY_ACT;
    logic [2:0] h;
    logic pa, sn;
    int mismatches = 0;
    int num_checks = 0;
    always #2.5 CLK = ~CLK;
    pcs_config_regs #(.MAKER_CODE(IDENT[15:0]), .PART_CODE(IDENT[31:16])) dut (
        .CLK(CLK), .RST_N(RST_N), .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA),
        .CFG_ACK(CFG_ACK), .MEM_REQ(MEM_REQ), .MEM_IS_LOCAL(MEM_IS_LOCAL),
        .IO_REQ(IO_REQ), .WIN_HIT(WIN_HIT), .LOCAL_HIT(LOCAL_HIT), .IO_HIT(IO_HIT),
        .TARGET_ABORT_EVT(TARGET_ABORT_EVT), .PARITY_ERR_EVT(PARITY_ERR_EVT),
        .SERR_EVT(SERR_EVT), .SYSTEM_ERROR_OUT_N(SYSTEM_ERROR_OUT_N),
        .PARITY_ACT(PARITY_ACT));
    pcs_host_model host (
        .CLK(CLK), .CFG_REQ(CFG_REQ), .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA),
        .MEM_REQ(MEM_REQ), .MEM_IS_LOCAL(MEM_IS_LOCAL), .IO_REQ(IO_REQ),
        .HITS({WIN_HIT, LOCAL_HIT, IO_HIT}));
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // register accesses, each answered exactly one cycle later
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic ack;
        host.cfg(1'b0, a, 4'hf, 32'h0, q, ack);
        chk({31'h0, ack}, 32'h1);
        chk(q, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic ack;
        host.cfg(1'b1, a, be, d, q, ack);
        chk({31'h0, ack}, 32'h1);
    endtask
    // one-cycle event pulse; parity action seen during it, error output after it
    task automatic pulse(input logic [2:0] ev);
        @(posedge CLK);
        #1;
        {TARGET_ABORT_EVT, PARITY_ERR_EVT, SERR_EVT} = ev;
        #1;
        pa = PARITY_ACT;
        @(posedge CLK);
        #1;
        {TARGET_ABORT_EVT, PARITY_ERR_EVT, SERR_EVT} = 3'h0;
        sn = SYSTEM_ERROR_OUT_N;
    endtask
    task automatic test_reset();
        rd(12'h010, 32'h0);
        rd(12'h03c, 32'h0f05_0100);
        rd(12'h100, IDENT);
        rd(12'h104, ST);
        rd(12'h008, 32'h0);
        $display("test_reset done");
    endtask
    task automatic test_win();
        wr(12'h010, 4'hf, 32'hffff_ffff);
        rd(12'h010, 32'hffff_f000);
        wr(12'h010, 4'h3, 32'h0);
        rd(12'h010, 32'hffff_0000);
        host.probe(32'hffff_0abc, 1'b0, 1'b0, h);
        chk({29'h0, h}, 32'h4);
        host.probe(32'hfffe_0abc, 1'b0, 1'b0, h);
        chk({29'h0, h}, 32'h0);
        $display("test_win done");
    endtask
    task automatic test_irq_ident();
        wr(12'h03c, 4'hf, 32'hffff_ffff);
        rd(12'h03c, 32'h0f05_01ff);
        wr(12'h03c, 4'he, 32'h0);
        rd(12'h03c, 32'h0f05_01ff);
        wr(12'h100, 4'hf, 32'h0);
        rd(12'h100, IDENT);
        $display("test_irq_ident done");
    endtask
    task automatic test_cmd();
        host.probe(32'h1234_5678, 1'b1, 1'b1, h);
        chk({29'h0, h}, 32'h0);
        wr(12'h104, 4'h3, 32'h0000_ffff);
        rd(12'h104, ST | 32'h0142);
        host.probe(32'h1234_5678, 1'b1, 1'b1, h);
        chk({29'h0, h}, 32'h2);
        wr(12'h104, 4'h3, 32'h0000_0100);
        host.probe(32'h1234_5678, 1'b1, 1'b0, h);
        chk({29'h0, h}, 32'h0);
        $display("test_cmd done");
    endtask
    task automatic test_status();
        wr(12'h104, 4'h3, 32'h0000_0040);
        pulse(3'h7);
        chk({30'h0, pa, sn}, 32'h3);
        rd(12'h104, ST | 32'hc800_0040);
        wr(12'h104, 4'hf, 32'h8000_0040);
        rd(12'h104, ST | 32'h4800_0040);
        wr(12'h104, 4'hf, 32'hffff_0100);
        rd(12'h104, ST | 32'h0100);
        pulse(3'h3);
        chk({30'h0, pa, sn}, 32'h0);
        rd(12'h104, ST | 32'hc000_0100);
        $display("test_status done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // run-length limit
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge CLK);
        #1;
        RST_N = 1'b1;
        test_reset();
        test_win();
        test_irq_ident();
        test_cmd();
        test_status();
        summarize();
    end
endmodule
`default_nettype wire
